// >>> dv/gpwi_assertions.sv
// gpwi_assertions: port-level checker for the gpio port.
// assumes it sees only the top module ports, bound below.
`timescale 1ns/100ps
`default_nettype none
module gpwi_chk
  import gpwi_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [NPIN_MAIN-1:0] pad_main_in_i,
  input wire logic [NPIN_MAIN-1:0] pad_main_out_o,
  input wire logic [NPIN_MAIN-1:0] pad_main_oe_o,
  input wire logic [NPIN_STBY-1:0] pad_stby_in_i,
  input wire logic [NPIN_STBY-1:0] pad_stby_out_o,
  input wire logic [NPIN_STBY-1:0] pad_stby_oe_o,
  input wire logic irq_o
);
  // ----------------------------------------
  // access phase and properties
  // ----------------------------------------
  logic acc;
  assign acc = psel_i && penable_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_dir_oe: assert property (acc && pwrite_i && paddr_i == OFF_DIR && pstrb_i == 4'hf
    |=> pad_main_oe_o[31:0] == $past(pwdata_i)) else $error("direction write missing on enables");
  a_oe_holds: assert property (!(acc && pwrite_i && paddr_i[11:4] == OFF_DIR[11:4])
    |=> $stable(pad_main_oe_o) && $stable(pad_stby_oe_o)) else $error("enables moved without write");
  a_out_word: assert property (acc && pwrite_i && paddr_i == OFF_OUT && pstrb_i == 4'hf
    |=> pad_main_out_o[31:0] == $past(pwdata_i)) else $error("output write missing on pads");
  a_out_lane: assert property (acc && pwrite_i && paddr_i == OFF_OUT && pstrb_i == 4'h2
    |=> pad_main_out_o[7:0] == $past(pad_main_out_o[7:0]) && pad_main_out_o[15:8] == $past(pwdata_i[15:8]))
    else $error("byte lane write wrong");
  a_ro_no_err: assert property (acc && (paddr_i == OFF_EXT || paddr_i == OFF_RAW || paddr_i == OFF_STAT)
    |-> !pslverr_o) else $error("read-only place gave error");
  a_stat_irq: assert property (acc && !pwrite_i && paddr_i == OFF_STAT && prdata_o != 32'h0
    |-> irq_o) else $error("masked status set but irq low");
  a_eoi_zero: assert property (acc && !pwrite_i && paddr_i == OFF_EOI
    |-> prdata_o == 32'h0) else $error("edge clear read not zero");
  a_irq_rst: assert property ($fell(sys_rst_i) |-> !irq_o) else $error("irq high after reset");
  c_eoi: cover property (acc && pwrite_i && paddr_i == OFF_EOI);
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (acc && pslverr_o);
endmodule : gpwi_chk
bind gpwi_top gpwi_chk u_chk (.core_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .pad_main_in_i, .pad_main_out_o, .pad_main_oe_o,
  .pad_stby_in_i, .pad_stby_out_o, .pad_stby_oe_o, .irq_o);
`default_nettype wire

// >>> dv/gpwi_pad_model.sv
// gpwi_pad_model: external pads and off-chip sources behind the port.
// assumes the bench supplies the far-side level of every pin.
`timescale 1ns/100ps
`default_nettype none
module gpwi_pad_model (
  input wire logic [86:0] out_i,
  input wire logic [86:0] oe_i,
  input wire logic [86:0] ext_i,
  output logic [86:0] lvl_o
);
  // a driven pad shows the port value, an undriven one the far side
  assign lvl_o = (oe_i & out_i) | (~oe_i & ext_i); // pad level
endmodule : gpwi_pad_model
`default_nettype wire

// >>> dv/tb_top.sv
// tb_top: directed tests of the gpio port over apb.
// assumes pad levels come from gpwi_pad_model.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import gpwi_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwd = 32'h0;
  logic [3:0] pst = 4'h0;
  logic [31:0] prd;
  logic prdy;
  logic perr;
  logic irq;
  logic [86:0] ext = 87'h0;
  logic [31:0] rd;
  logic er;
  wire logic [86:0] dout;
  wire logic [86:0] doe;
  wire logic [86:0] lvl;
  int errors = 0;
  int cmp_count = 0;
  // ----------------------------------------
  // clock, design and pads
  // ----------------------------------------
  always #2.5 clk = ~clk;
  gpwi_top u_dut (.core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwd), .pstrb_i(pst), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .pad_main_in_i(lvl[66:0]), .pad_main_out_o(dout[66:0]), .pad_main_oe_o(doe[66:0]),
    .pad_stby_in_i(lvl[86:67]), .pad_stby_out_o(dout[86:67]), .pad_stby_oe_o(doe[86:67]), .irq_o(irq));
  gpwi_pad_model u_pads (.out_i(dout), .oe_i(doe), .ext_i(ext), .lvl_o(lvl));
  // ----------------------------------------
  // bus, compare and closing tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    pst <= s;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) begin
      @(posedge clk);
    end
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_io;
    apb(1'b1, OFF_DIR, 32'h0000_0f00, 4'hf);
    chk(doe[31:0], 32'h0000_0f00); // enables
    apb(1'b1, OFF_OUT, 32'hffff_ffff, 4'hf);
    apb(1'b1, OFF_OUT, 32'h1234_0a00, 4'h2);
    chk(dout[31:0], 32'hffff_0aff); // lane
    apb(1'b1, OFF_DIR + 12'h008, 32'hffff_ffff, 4'hf);
    chk({9'h0, doe[86:64]}, 32'h007f_ffff); // standby
    apb(1'b1, OFF_OUT + 12'h008, 32'hffff_ffff, 4'hf);
    chk({9'h0, dout[86:64]}, 32'h007f_ffff); // standby out
    apb(1'b1, OFF_DIR + 12'h008, 32'h0, 4'hf);
    apb(1'b1, OFF_EXT, 32'hffff_ffff, 4'hf);
    apb(1'b0, OFF_EXT, 32'h0, 4'h0);
    chk(rd, 32'h0000_0a00); // pad levels
    apb(1'b0, 12'h00c, 32'h0, 4'h0);
    chk({31'h0, er}, 32'h1);
    $display("test io done");
  endtask : t_io
  task automatic t_edge;
    @(posedge clk);
    ext[5:4] <= 2'b01;
    apb(1'b1, OFF_TYPE, 32'h30, 4'hf);
    apb(1'b1, OFF_POL, 32'h20, 4'hf);
    apb(1'b1, OFF_IEN, 32'h30, 4'hf);
    apb(1'b0, OFF_RAW, 32'h0, 4'h0);
    chk(rd, 32'h0); // quiet
    @(posedge clk);
    ext[5:4] <= 2'b10;
    repeat (4) @(posedge clk);
    apb(1'b0, OFF_RAW, 32'h0, 4'h0);
    chk(rd, 32'h30); // rise and fall
    apb(1'b0, OFF_STAT, 32'h0, 4'h0);
    chk(rd, 32'h30); // masked
    chk({31'h0, irq}, 32'h1); // combined
    apb(1'b1, OFF_MASK, 32'h30, 4'hf);
    apb(1'b0, OFF_STAT, 32'h0, 4'h0);
    chk(rd, 32'h0); // masked
    apb(1'b0, OFF_RAW, 32'h0, 4'h0);
    chk(rd, 32'h30); // raw
    chk({31'h0, irq}, 32'h0); // all masked
    apb(1'b1, OFF_MASK, 32'h0, 4'hf);
    apb(1'b1, OFF_EOI, 32'h30, 4'hf);
    apb(1'b0, OFF_EOI, 32'h0, 4'h0);
    apb(1'b0, OFF_RAW, 32'h0, 4'h0);
    chk(rd, 32'h0); // both cleared
    chk({31'h0, irq}, 32'h0); // request dropped
    $display("test edge done");
  endtask : t_edge
  task automatic t_level;
    apb(1'b1, OFF_IEN, 32'h40, 4'hf);
    apb(1'b0, OFF_RAW, 32'h0, 4'h0);
    chk(rd, 32'h40); // low level
    apb(1'b1, OFF_EOI, 32'h40, 4'hf);
    apb(1'b0, OFF_RAW, 32'h0, 4'h0);
    chk(rd, 32'h40); // clear ignored
    apb(1'b1, OFF_OUT, 32'h40, 4'h1);
    apb(1'b1, OFF_DIR, 32'h0f40, 4'hf);
    repeat (4) @(posedge clk);
    apb(1'b0, OFF_RAW, 32'h0, 4'h0);
    chk(rd, 32'h40); // held as output
    apb(1'b1, OFF_LSYNC, 32'h40, 4'hf);
    @(posedge clk);
    ext[6] <= 1'b1;
    apb(1'b1, OFF_DIR, 32'h0f00, 4'hf);
    repeat (4) @(posedge clk);
    apb(1'b0, OFF_RAW, 32'h0, 4'h0);
    chk(rd, 32'h0); // synced level gone
    apb(1'b1, OFF_POL, 32'h60, 4'hf);
    repeat (4) @(posedge clk);
    apb(1'b0, OFF_RAW, 32'h0, 4'h0);
    chk(rd, 32'h40); // high level
    $display("test level done");
  endtask : t_level
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_io();
    t_edge();
    t_level();
    finish_test();
  end
  initial begin
    #10000;
    errors++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire

// >>> rtl/gpwi_irq_cell.sv
// gpwi_irq_cell: per-pin trigger detection and raw interrupt status.
// assumes lvl_i is already synchronised to core_clk_i.
`timescale 1ns/100ps
`default_nettype none
module gpwi_irq_cell #(
  parameter int W = 87
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] lvl_i,
  input wire logic [W-1:0] is_input_i,
  input wire logic [W-1:0] ien_i,
  input wire logic [W-1:0] edge_mode_i,
  input wire logic [W-1:0] pol_i,
  input wire logic [W-1:0] lsync_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] raw_o
);

  logic [W-1:0] prev_ff;
  logic [W-1:0] edge_ff;
  logic [W-1:0] lvl_ff;
  logic [W-1:0] nxt_prev;
  logic [W-1:0] nxt_edge;
  logic [W-1:0] nxt_lvl;
  logic [W-1:0] hit;
  logic [W-1:0] arm;
  logic [W-1:0] act;

  // edge and level detection; a new event beats a clear in the same cycle
  always_comb begin
    hit = (pol_i & lvl_i & ~prev_ff) | (~pol_i & ~lvl_i & prev_ff);
    arm = ien_i & is_input_i;
    act = ~(pol_i ^ lvl_i);
    nxt_prev = lvl_i;
    nxt_edge = edge_mode_i & ((edge_ff & ~clr_i) | (hit & arm));
    nxt_lvl = ien_i & ((is_input_i & act) | (~is_input_i & lvl_ff));
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prev_ff <= '0;
      edge_ff <= '0;
      lvl_ff <= '0;
    end else begin
      prev_ff <= nxt_prev;
      edge_ff <= nxt_edge;
      lvl_ff <= nxt_lvl;
    end
  end

  // edge status always registered; level status registered when chosen or when the pin is an output
  assign raw_o = (edge_mode_i & edge_ff) |
                 (~edge_mode_i & (lsync_i | ~is_input_i) & lvl_ff) |
                 (~edge_mode_i & ~lsync_i & is_input_i & ien_i & act);

endmodule : gpwi_irq_cell
`default_nettype wire

// >>> rtl/gpwi_pkg.sv
// gpwi_pkg: constants, register map and word helpers for the gpio port with interrupts.
// assumes a 32-bit apb slave on core_clk_i, registers three aligned words each.
//
// How it works
// - 67 pins in the main domain plus 20 standby pins, each set up alone.
// - direction register bit sets pad direction; driver enabled only for outputs.
// - output value register bit drives each pad output buffer.
// - read-only input register shows every pad level; writes ignored.
// - each pin selects high level, low level, rising or falling trigger.
// - per-pin mask; raw status and masked status both readable.
// - all masked interrupts ORed onto one active-high output, no own mask.
// - only input pins latch new interrupts; pending ones survive turning to output.
// - writing 1 to edge clear bits clears edge pins' raw and masked status.
// - edge clear ignored for level pins; they request while source is active.
// - edge inputs always synchronised; level synchronisation chosen by software.
package gpwi_pkg;

  // ---------------------------------------------------------------
  // pin counts and vector layout
  // ---------------------------------------------------------------
  localparam int NPIN_MAIN = 67;
  localparam int NPIN_STBY = 20;
  localparam int NPIN = NPIN_MAIN + NPIN_STBY;
  localparam int NWORD = 3;              // 32-bit words per pin vector
  localparam int VW = 32 * NWORD;        // padded vector width
  localparam logic [VW-1:0] PIN_MASK = {{(VW - NPIN){1'b0}}, {NPIN{1'b1}}};

  // ---------------------------------------------------------------
  // register map: byte offsets, word n of a register at offset + 4*n
  // ---------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] OFF_OUT = 12'h000;   // output_value_reg
  localparam logic [APB_AW-1:0] OFF_DIR = 12'h010;   // direction, 1 = output
  localparam logic [APB_AW-1:0] OFF_IEN = 12'h020;   // interrupt enable
  localparam logic [APB_AW-1:0] OFF_TYPE = 12'h030;  // 1 = edge, 0 = level
  localparam logic [APB_AW-1:0] OFF_POL = 12'h040;   // 1 = high/rising, 0 = low/falling
  localparam logic [APB_AW-1:0] OFF_MASK = 12'h050;  // 1 = masked
  localparam logic [APB_AW-1:0] OFF_LSYNC = 12'h060; // 1 = level input synchronised
  localparam logic [APB_AW-1:0] OFF_STAT = 12'h070;  // masked status, read only
  localparam logic [APB_AW-1:0] OFF_RAW = 12'h080;   // raw status, read only
  localparam logic [APB_AW-1:0] OFF_EOI = 12'h090;   // edge clear, write only
  localparam logic [APB_AW-1:0] OFF_EXT = 12'h0a0;   // pad input level, read only
  localparam int KIND_LSB = 4;                       // offset bits naming the register
  localparam int WORD_LSB = 2;                       // offset bits naming the word

  // reset value of every control register
  localparam logic [VW-1:0] RST_CTRL = {VW{1'b0}};
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // ---------------------------------------------------------------
  // helpers shared by the register file
  // ---------------------------------------------------------------
  function automatic logic [31:0] word_get(input logic [VW-1:0] v, input logic [1:0] idx);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (int'(idx) < NWORD) begin
      r = v[int'(idx) * 32 +: 32];
    end
    return r;
  endfunction : word_get

  function automatic logic [VW-1:0] word_put(input logic [VW-1:0] v, input logic [1:0] idx,
                                              input logic [31:0] d, input logic [3:0] be);
    logic [VW-1:0] r;
    r = v;
    for (int b = 0; b < 4; b++) begin
      if (be[b] && int'(idx) < NWORD) begin
        r[int'(idx) * 32 + b * 8 +: 8] = d[b * 8 +: 8];
      end
    end
    return r & PIN_MASK;
  endfunction : word_put

endpackage : gpwi_pkg

// >>> rtl/gpwi_sync.sv
// gpwi_sync: two-flop synchroniser for a vector of pad inputs.
// assumes each bit is an independent level; no bus coherence across bits.
`timescale 1ns/100ps
`default_nettype none
module gpwi_sync #(
  parameter int W = 87
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // first stage feeds only the second stage
  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_o = sync_ff;

endmodule : gpwi_sync
`default_nettype wire

// >>> rtl/gpwi_top.sv
// gpwi_top: gpio port with per-pin direction, output value, input sample and interrupts.
// assumes an apb master on core_clk_i and pads that resolve level from out and enable.
// pad inputs are asynchronous and pass two flops before any logic reads them.
// reset is synchronous and active high; the bus is answered with no wait states.
// all pins share one clock; the standby pins are only a second group of bits.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module gpwi_top
  import gpwi_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // main domain pads
  input wire logic [NPIN_MAIN-1:0] pad_main_in_i,
  output logic [NPIN_MAIN-1:0] pad_main_out_o,
  output logic [NPIN_MAIN-1:0] pad_main_oe_o,
  // standby domain pads
  input wire logic [NPIN_STBY-1:0] pad_stby_in_i,
  output logic [NPIN_STBY-1:0] pad_stby_out_o,
  output logic [NPIN_STBY-1:0] pad_stby_oe_o,
  // combined interrupt, active high
  output logic irq_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [VW-1:0] output_value_reg_ff;
  logic [VW-1:0] dir_ff;
  logic [VW-1:0] ien_ff;
  logic [VW-1:0] type_ff;
  logic [VW-1:0] pol_ff;
  logic [VW-1:0] mask_ff;
  logic [VW-1:0] lsync_ff;
  logic [31:0] prdata_ff;
  logic irq_ff;
  logic [VW-1:0] nxt_output_value_reg;
  logic [VW-1:0] nxt_dir;
  logic [VW-1:0] nxt_ien;
  logic [VW-1:0] nxt_type;
  logic [VW-1:0] nxt_pol;
  logic [VW-1:0] nxt_mask;
  logic [VW-1:0] nxt_lsync;
  logic [31:0] nxt_prdata;
  logic nxt_irq;

  logic [NPIN-1:0] pad_sync;
  logic [NPIN-1:0] raw_pin;
  logic [VW-1:0] ext_v;
  logic [VW-1:0] raw_v;
  logic [VW-1:0] stat_v;
  logic [VW-1:0] eoi_v;

  logic setup;
  logic access;
  logic wr_acc;
  logic [3:0] kind;
  logic [1:0] widx;
  logic addr_ok;
  logic [31:0] rd_word;

  // write strobes, one per stored register
  logic we_out;
  logic we_dir;
  logic we_ien;
  logic we_type;
  logic we_pol;
  logic we_mask;
  logic we_lsync;

  // ---------------------------------------------------------------
  // pad input synchronisation
  // ---------------------------------------------------------------
  // every pad passes two flops before any logic looks at it
  // the input register reads the same synchronised vector that interrupts see
  gpwi_sync #(
    .W(NPIN)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({pad_stby_in_i, pad_main_in_i}),
    .sync_o(pad_sync)
  );

  assign ext_v = {{(VW - NPIN){1'b0}}, pad_sync};

  // ---------------------------------------------------------------
  // interrupt detection
  // ---------------------------------------------------------------
  // direction bit 0 means input; only inputs may latch new events
  // pending status survives a switch to output; nothing new latches there
  gpwi_irq_cell #(
    .W(NPIN)
  ) u_irq (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .lvl_i(pad_sync),
    .is_input_i(~dir_ff[NPIN-1:0]),
    .ien_i(ien_ff[NPIN-1:0]),
    .edge_mode_i(type_ff[NPIN-1:0]),
    .pol_i(pol_ff[NPIN-1:0]),
    .lsync_i(lsync_ff[NPIN-1:0]),
    .clr_i(eoi_v[NPIN-1:0]),
    .raw_o(raw_pin)
  );

  // raw and post-mask status vectors
  // masked pins still show in raw status, so software can poll them
  always_comb begin
    raw_v = {{(VW - NPIN){1'b0}}, raw_pin};
    stat_v = raw_v & ~mask_ff;
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // zero wait states: every access phase completes at its first edge
  // an unmapped word answers with pslverr, reads zero and drops a write
  always_comb begin
    setup = psel_i & ~penable_i;
    access = psel_i & penable_i;
    kind = paddr_i[KIND_LSB +: 4];
    widx = paddr_i[WORD_LSB +: 2];
    addr_ok = (paddr_i[APB_AW-1:KIND_LSB+4] == '0) && (int'(widx) < NWORD) &&
              (kind <= OFF_EXT[KIND_LSB +: 4]);
    wr_acc = access & pwrite_i & addr_ok;
  end

  assign pready_o = 1'b1;
  assign pslverr_o = access & ~addr_ok;

  // edge clear pulse: one cycle, bits written as 1 in the edge clear word
  // level pins are cut here, so a clear never reaches their status
  always_comb begin
    eoi_v = '0;
    if (wr_acc && kind == OFF_EOI[KIND_LSB +: 4]) begin
      eoi_v = word_put('0, widx, pwdata_i, pstrb_i) & type_ff;
    end
  end

  // ---------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------
  // the edge clear register and unmapped words read as zero
  // status words are read live; a read returns their state at the setup edge
  always_comb begin
    rd_word = RST_RDATA;
    unique case (kind)
      OFF_OUT[KIND_LSB +: 4]: rd_word = word_get(output_value_reg_ff, widx);
      OFF_DIR[KIND_LSB +: 4]: rd_word = word_get(dir_ff, widx);
      OFF_IEN[KIND_LSB +: 4]: rd_word = word_get(ien_ff, widx);
      OFF_TYPE[KIND_LSB +: 4]: rd_word = word_get(type_ff, widx);
      OFF_POL[KIND_LSB +: 4]: rd_word = word_get(pol_ff, widx);
      OFF_MASK[KIND_LSB +: 4]: rd_word = word_get(mask_ff, widx);
      OFF_LSYNC[KIND_LSB +: 4]: rd_word = word_get(lsync_ff, widx);
      OFF_STAT[KIND_LSB +: 4]: rd_word = word_get(stat_v, widx);
      OFF_RAW[KIND_LSB +: 4]: rd_word = word_get(raw_v, widx);
      OFF_EXT[KIND_LSB +: 4]: rd_word = word_get(ext_v, widx);
      default: rd_word = RST_RDATA;
    endcase
    if (!addr_ok) begin
      rd_word = RST_RDATA;
    end
  end

  // ---------------------------------------------------------------
  // register write strobes
  // ---------------------------------------------------------------
  // register field of a byte offset, the part that names the register
  function automatic logic [3:0] kind_of(input logic [APB_AW-1:0] off);
    return off[KIND_LSB +: 4];
  endfunction : kind_of

  // one strobe per stored register; the status, raw, edge clear and input
  // words have none; a status, raw or input write completes and is lost
  always_comb begin
    we_out = wr_acc && (kind == kind_of(OFF_OUT));
    we_dir = wr_acc && (kind == kind_of(OFF_DIR));
    we_ien = wr_acc && (kind == kind_of(OFF_IEN));
    we_type = wr_acc && (kind == kind_of(OFF_TYPE));
    we_pol = wr_acc && (kind == kind_of(OFF_POL));
    we_mask = wr_acc && (kind == kind_of(OFF_MASK));
    we_lsync = wr_acc && (kind == kind_of(OFF_LSYNC));
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // writes land at the access edge, one byte lane per strobe bit; bits
  // above the last pin never store, so they always read back as zero
  always_comb begin
    nxt_output_value_reg = output_value_reg_ff;
    nxt_dir = dir_ff;
    nxt_ien = ien_ff;
    nxt_type = type_ff;
    nxt_pol = pol_ff;
    nxt_mask = mask_ff;
    nxt_lsync = lsync_ff;
    if (we_out) begin
      nxt_output_value_reg = word_put(output_value_reg_ff, widx, pwdata_i, pstrb_i);
    end
    if (we_dir) begin
      nxt_dir = word_put(dir_ff, widx, pwdata_i, pstrb_i);
    end
    if (we_ien) begin
      nxt_ien = word_put(ien_ff, widx, pwdata_i, pstrb_i);
    end
    if (we_type) begin
      nxt_type = word_put(type_ff, widx, pwdata_i, pstrb_i);
    end
    if (we_pol) begin
      nxt_pol = word_put(pol_ff, widx, pwdata_i, pstrb_i);
    end
    if (we_mask) begin
      nxt_mask = word_put(mask_ff, widx, pwdata_i, pstrb_i);
    end
    if (we_lsync) begin
      nxt_lsync = word_put(lsync_ff, widx, pwdata_i, pstrb_i);
    end
  end

  // reset leaves every pin an input, level, active low, disabled, unmasked
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      output_value_reg_ff <= RST_CTRL;
      dir_ff <= RST_CTRL;
      ien_ff <= RST_CTRL;
      type_ff <= RST_CTRL;
      pol_ff <= RST_CTRL;
      mask_ff <= RST_CTRL;
      lsync_ff <= RST_CTRL;
    end else begin
      output_value_reg_ff <= nxt_output_value_reg;
      dir_ff <= nxt_dir;
      ien_ff <= nxt_ien;
      type_ff <= nxt_type;
      pol_ff <= nxt_pol;
      mask_ff <= nxt_mask;
      lsync_ff <= nxt_lsync;
    end
  end

  // ---------------------------------------------------------------
  // read data register
  // ---------------------------------------------------------------
  // captured at the setup edge so it is settled through the whole access
  // phase; a write setup loads zero so old data never shows on a write
  always_comb begin
    nxt_prdata = prdata_ff;
    if (setup) begin
      nxt_prdata = pwrite_i ? RST_RDATA : rd_word;
    end
  end

  // the register only moves at a setup edge, never in the access phase
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prdata_ff <= RST_RDATA;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ---------------------------------------------------------------
  // combined interrupt
  // ---------------------------------------------------------------
  // single request from all masked pins, no mask of its own; registered so
  // the output carries no glitch from the status logic, one cycle behind it
  always_comb begin
    nxt_irq = |stat_v;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // pins 0..66 form the main domain, 67..86 the standby domain
  // an enable of 1 drives the pad; 0 leaves the level to the far side
  assign pad_main_out_o = output_value_reg_ff[NPIN_MAIN-1:0];
  assign pad_stby_out_o = output_value_reg_ff[NPIN-1:NPIN_MAIN];
  assign pad_main_oe_o = dir_ff[NPIN_MAIN-1:0];
  assign pad_stby_oe_o = dir_ff[NPIN-1:NPIN_MAIN];
  assign prdata_o = prdata_ff;
  assign irq_o = irq_ff;

endmodule : gpwi_top
`default_nettype wire
